// ### pkg/pec_pkg.sv
// Purpose: Shared constants for the print engine coordinator
// Assumes: 250 MHz system clock, APB register access
// Notes: Byte addresses of the register words, status bit positions
package pec_pkg;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_PANEL = 8'h0C;
    localparam logic [7:0] A_PAPER = 8'h10;
    localparam logic [7:0] A_SERIAL = 8'h14;
    localparam logic [7:0] A_ROW = 8'h18;
    localparam logic [7:0] A_MSG = 8'h1C;
    // Status and mask bit positions
    localparam int ST_SHORT = 0;
    localparam int ST_HAMMER = 1;
    localparam int ST_STALL = 2;
    localparam int ST_PLATEN = 3;
    localparam int ST_PAPER = 4;
    localparam int ST_SVC = 5;
    localparam int ST_RSP = 6;
    localparam int ST_RX = 7;
    localparam logic [7:0] FAULT_BITS = 8'h5F;
    // Control bits
    localparam int CT_PRINT = 0;
    localparam int CT_SAMPLE = 1;
    localparam int CT_DISPLAY = 2;
    localparam int CT_INDIC = 3;
    // Fault flags inside received bytes
    localparam int PAPER_OUT_BIT = 0;
    localparam int PAPER_MOTION_BIT = 1;
    localparam int RSP_FAULT_BIT = 7;
    // Widths and counts
    localparam int BUS_W = 16;
    localparam int PIN_W = 9;
    localparam int PORT_W = 8;
    localparam int COILS = 48;
    localparam int TABLE_WORDS = 16;
    localparam int PANEL_HALF = 4;
    localparam int SYNC_W = 26;
    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD = 2400;
    localparam int BAUD_DIV = CLK_HZ / BAUD;
    localparam int STALL_TIME_US = 4000;
    localparam int STALL_CYC = STALL_TIME_US * (CLK_HZ / 1_000_000);
endpackage : pec_pkg

// ### hdl/pec_top.sv
// Purpose: Real-time coordination logic of the printer common controller
// Assumes: One clock, APB slave, pins pass two flip-flops first
// Notes: All state in one packed struct
// What this block does
// - Shared sixteen-bit bus granted every cycle
// - Nine-bit input word moved in one cycle
// - DMA byte address shifted left one bit
// - Panel shift port plus three strobe bits
// - Program per row and stroke, table DMA
// - Paper command over port moves immediately
// - Only this unit starts serial transactions
// - One coil per stroke, 48 strokes
// - Coil short halts before next row
// - Watch hammer faults, stalls, open platen
// - Any fault sends message to processing unit
// - Burst requested at row-set pickup count
// - Serial link asynchronous at 2400 baud
`timescale 1ns/1ps
module pec_top #(
    parameter int BAUD_DIV = pec_pkg::BAUD_DIV,
    parameter int STALL_CYC = pec_pkg::STALL_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    input wire logic dpu_req_in,
    output logic grant_dpu_out,
    output logic grant_rtu_out,
    input wire logic dma_req_in,
    input wire logic [15:0] dma_addr_in,
    input wire logic [8:0] pdata_in,
    output logic [16:0] mem_addr_out,
    output logic [15:0] mem_data_out,
    output logic mem_we_out,
    output logic panel_sclk_out,
    output logic panel_sdo_out,
    input wire logic panel_sdi_in,
    output logic panel_sample_out,
    output logic panel_display_out,
    output logic panel_indicator_out,
    output logic dot_plucker_load_out,
    output logic fire_timer_load_out,
    input wire logic stroke_in,
    input wire logic pickup_pulse_in,
    output logic burst_req_out,
    output logic table_dma_req_out,
    output logic [7:0] table_addr_out,
    output logic table_load_out,
    output logic [7:0] paper_data_out,
    output logic paper_stb_out,
    output logic paper_now_out,
    output logic paper_trig_out,
    input wire logic [7:0] paper_status_in,
    input wire logic paper_status_stb_in,
    output logic rsp_tx_out,
    input wire logic rsp_rx_in,
    input wire logic rsp_service_in,
    output logic [5:0] coil_sel_out,
    input wire logic coil_short_in,
    input wire logic hammer_fault_in,
    input wire logic platen_open_in,
    output logic fire_enable_out,
    output logic [7:0] dpu_msg_out,
    output logic dpu_msg_valid_out
);
    typedef struct packed {
        logic [25:0] s1, s2, s3;
        logic pready, pslverr;
        logic [31:0] prdata;
        logic print_en, irq;
        logic [7:0] stat, mask;
        logic last_rtu, grant_dpu, grant_rtu, dma_pend, mem_we;
        logic [16:0] mem_addr;
        logic [15:0] mem_data;
        logic [3:0] pan_div;
        logic [3:0] pan_bit;
        logic [7:0] pan_sh, keys;
        logic pan_sclk, pan_busy, pan_sample, pan_disp, pan_ind;
        logic dp_load, ft_load, burst_req, burst_done;
        logic [7:0] burst_time, move_dist, pk_cnt;
        logic tbl_busy, tbl_load;
        logic [7:0] tbl_addr;
        logic [7:0] paper_data, paper_stat;
        logic paper_stb, paper_now, paper_trig;
        logic [5:0] coil;
        logic fire_en;
        logic [31:0] stall_cnt, tx_div, rx_div;
        logic [3:0] tx_bit, rx_bit;
        logic [9:0] tx_sh;
        logic tx_busy, tx_line, rx_busy;
        logic [7:0] rx_sh, rx_byte, msg;
        logic msg_valid;
    } pec_state_s;

    pec_state_s s, next_s;
    logic [25:0] raw;
    logic wr, rd, wr_ctrl, wr_stat, wr_paper, wr_serial, wr_row, wr_panel, tx_start;
    logic stroke_rise, pick_rise, pstb_rise, rx_line;
    logic [7:0] ev, clr;

    // Pin inputs gathered for the two-stage synchroniser
    assign raw = {paper_status_in, pdata_in, pickup_pulse_in, stroke_in, coil_short_in,
                  hammer_fault_in, platen_open_in, rsp_rx_in, rsp_service_in,
                  panel_sdi_in, paper_status_stb_in};
    // Edges seen after the second stage only
    assign pstb_rise = s.s2[0] & ~s.s3[0];
    assign stroke_rise = s.s2[7] & ~s.s3[7];
    assign pick_rise = s.s2[8] & ~s.s3[8];
    assign rx_line = s.s2[3];
    // APB access phase decode, write takes effect when pready is high
    assign wr = psel_in & penable_in & s.pready & pwrite_in;
    assign rd = psel_in & penable_in & ~s.pready;
    assign wr_ctrl = wr && paddr_in == pec_pkg::A_CTRL;
    assign wr_stat = wr && paddr_in == pec_pkg::A_STAT;
    assign wr_paper = wr && paddr_in == pec_pkg::A_PAPER;
    assign wr_serial = wr && paddr_in == pec_pkg::A_SERIAL;
    assign wr_row = wr && paddr_in == pec_pkg::A_ROW;
    assign wr_panel = wr && paddr_in == pec_pkg::A_PANEL;
    assign tx_start = wr_serial & ~s.tx_busy;
    assign clr = wr_stat ? pwdata_in[7:0] : 8'h00;

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;
        ev = 8'h00;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        // APB slave: one wait state, error on unmapped address
        next_s.pready = rd;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr_in)
                pec_pkg::A_CTRL: next_s.prdata = {31'h0, s.print_en};
                pec_pkg::A_STAT: next_s.prdata = {24'h0, s.stat};
                pec_pkg::A_MASK: next_s.prdata = {24'h0, s.mask};
                pec_pkg::A_PANEL: next_s.prdata = {23'h0, s.pan_busy, s.keys};
                pec_pkg::A_PAPER: next_s.prdata = {24'h0, s.paper_stat};
                pec_pkg::A_SERIAL: next_s.prdata = {23'h0, s.tx_busy, s.rx_byte};
                pec_pkg::A_ROW: next_s.prdata = {16'h0, s.burst_time, s.move_dist};
                pec_pkg::A_MSG: next_s.prdata = {15'h0, s.stat[pec_pkg::ST_SHORT],
                                                 2'h0, s.coil, s.msg};
                default: next_s.pslverr = 1'b1;
            endcase
        end
        next_s.pan_sample = wr_ctrl & pwdata_in[pec_pkg::CT_SAMPLE];
        next_s.pan_disp = wr_ctrl & pwdata_in[pec_pkg::CT_DISPLAY];
        next_s.pan_ind = wr_ctrl & pwdata_in[pec_pkg::CT_INDIC];
        if (wr_ctrl) begin
            next_s.print_en = pwdata_in[pec_pkg::CT_PRINT];
        end
        if (wr && paddr_in == pec_pkg::A_MASK) begin
            next_s.mask = pwdata_in[7:0];
        end
        // panel synchronous shift, data out on fall, keys in on rise
        if (wr_panel && !s.pan_busy) begin
            next_s.pan_sh = pwdata_in[7:0];
            next_s.pan_busy = 1'b1;
            next_s.pan_bit = 4'h0;
            next_s.pan_div = 4'h0;
        end else if (s.pan_busy) begin
            next_s.pan_div = s.pan_div + 4'h1;
            if (s.pan_div == 4'(pec_pkg::PANEL_HALF - 1)) begin
                next_s.pan_div = 4'h0;
                next_s.pan_sclk = ~s.pan_sclk;
                next_s.pan_bit = s.pan_bit + 4'h1;
                if (s.pan_sclk) begin
                    next_s.pan_sh = {s.pan_sh[6:0], 1'b0};
                end else begin
                    next_s.keys = {s.keys[6:0], s.s2[1]};
                end
                if (s.pan_bit == 4'hF) begin
                    next_s.pan_busy = 1'b0;
                end
            end
        end
        // per-cycle grant, alternating when both ask
        next_s.grant_rtu = s.dma_pend & (~dpu_req_in | ~s.last_rtu);
        next_s.grant_dpu = dpu_req_in & ~next_s.grant_rtu;
        if (next_s.grant_rtu | next_s.grant_dpu) begin
            next_s.last_rtu = next_s.grant_rtu;
        end
        // whole nine-bit word written in one bus cycle
        next_s.mem_we = next_s.grant_rtu;
        if (next_s.grant_rtu) begin
            next_s.dma_pend = 1'b0;
        end
        // byte address doubled for word transfers
        if (dma_req_in && !s.dma_pend) begin
            next_s.dma_pend = 1'b1;
            next_s.mem_addr = {dma_addr_in, 1'b0};
            next_s.mem_data = {7'h00, s.s2[17:9]};
        end
        ev[pec_pkg::ST_SHORT] = s.s2[6] & ~s.s3[6];
        ev[pec_pkg::ST_HAMMER] = s.s2[5] & ~s.s3[5];
        ev[pec_pkg::ST_PLATEN] = s.s2[4] & ~s.s3[4];
        if (pick_rise || !s.print_en) begin
            next_s.stall_cnt = 32'h0;
        end else if (s.stall_cnt != 32'(STALL_CYC)) begin
            next_s.stall_cnt = s.stall_cnt + 32'h1;
            ev[pec_pkg::ST_STALL] = s.stall_cnt == 32'(STALL_CYC - 1);
        end
        // paper status byte taken on its strobe
        if (pstb_rise) begin
            next_s.paper_stat = s.s2[25:18];
            ev[pec_pkg::ST_PAPER] = s.s2[18 + pec_pkg::PAPER_OUT_BIT]
                                  | s.s2[18 + pec_pkg::PAPER_MOTION_BIT];
        end
        // far processor asks for service by an edge
        ev[pec_pkg::ST_SVC] = s.s2[2] & ~s.s3[2];
        // transmitter, start bit, eight data bits, stop bit
        next_s.tx_line = s.tx_sh[0];
        if (tx_start) begin
            next_s.tx_sh = {1'b1, pwdata_in[7:0], 1'b0};
            next_s.tx_busy = 1'b1;
            next_s.tx_div = 32'h0;
            next_s.tx_bit = 4'h0;
        end else if (s.tx_busy) begin
            next_s.tx_div = s.tx_div + 32'h1;
            if (s.tx_div == 32'(BAUD_DIV - 1)) begin
                next_s.tx_div = 32'h0;
                next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
                next_s.tx_bit = s.tx_bit + 4'h1;
                next_s.tx_busy = s.tx_bit != 4'h9;
            end
        end
        // receiver samples mid-bit, false start dropped
        if (!s.rx_busy) begin
            if (!rx_line) begin
                next_s.rx_busy = 1'b1;
                next_s.rx_div = 32'h0;
                next_s.rx_bit = 4'h0;
            end
        end else begin
            next_s.rx_div = s.rx_div + 32'h1;
            if (s.rx_div == 32'((s.rx_bit == 4'h0) ? BAUD_DIV / 2 - 1 : BAUD_DIV - 1)) begin
                next_s.rx_div = 32'h0;
                next_s.rx_bit = s.rx_bit + 4'h1;
                if (s.rx_bit == 4'h0 && rx_line) begin
                    next_s.rx_busy = 1'b0;
                end else if (s.rx_bit == 4'h9) begin
                    next_s.rx_busy = 1'b0;
                    if (rx_line) begin
                        next_s.rx_byte = s.rx_sh;
                        ev[pec_pkg::ST_RX] = 1'b1;
                        ev[pec_pkg::ST_RSP] = s.rx_sh[pec_pkg::RSP_FAULT_BIT];
                    end
                end else if (s.rx_bit != 4'h0) begin
                    next_s.rx_sh = {rx_line, s.rx_sh[7:1]};
                end
            end
        end
        // sticky status, set beats the one-to-clear write
        next_s.stat = (s.stat & ~clr) | ev;
        // service flag dropped when a transaction starts or by a one-to-clear write
        if (tx_start && !ev[pec_pkg::ST_SVC]) begin
            next_s.stat[pec_pkg::ST_SVC] = 1'b0;
        end
        next_s.irq = |(next_s.stat & s.mask);
        // collated fault message to the processing unit
        next_s.msg_valid = |(ev & pec_pkg::FAULT_BITS);
        if (next_s.msg_valid) begin
            next_s.msg = ev & pec_pkg::FAULT_BITS;
        end
        // firing stops while a coil short stands
        next_s.fire_en = s.print_en & ~next_s.stat[pec_pkg::ST_SHORT];
        // dot plucker programmed per row; move prepared
        next_s.dp_load = wr_row & next_s.fire_en;
        next_s.paper_stb = wr_row | wr_paper;
        // port command moves paper at once
        next_s.paper_now = wr_paper;
        if (wr_row) begin
            next_s.burst_time = pwdata_in[15:8];
            next_s.move_dist = pwdata_in[7:0];
            next_s.paper_data = pwdata_in[7:0];
        end else if (wr_paper) begin
            next_s.paper_data = pwdata_in[7:0];
        end
        // fire timer reloaded per stroke, trigger paper move
        next_s.ft_load = stroke_rise;
        next_s.paper_trig = stroke_rise & next_s.fire_en;
        next_s.tbl_load = s.tbl_busy;
        if (stroke_rise) begin
            next_s.tbl_busy = 1'b1;
            next_s.tbl_addr = 8'h00;
            next_s.pk_cnt = 8'h00;
            next_s.burst_done = 1'b0;
            // next coil checked, wraps after the last
            next_s.coil = (s.coil == 6'(pec_pkg::COILS - 1)) ? 6'h00 : s.coil + 6'h01;
        end else if (s.tbl_busy) begin
            next_s.tbl_addr = s.tbl_addr + 8'h01;
            next_s.tbl_busy = s.tbl_addr != 8'(pec_pkg::TABLE_WORDS - 1);
        end
        // burst at the pickup count written with the row
        next_s.burst_req = 1'b0;
        if (pick_rise && !stroke_rise) begin
            next_s.pk_cnt = s.pk_cnt + 8'h01;
            if (s.pk_cnt + 8'h01 == s.burst_time && !s.burst_done && next_s.fire_en) begin
                next_s.burst_req = 1'b1;
                next_s.burst_done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
            s.tx_sh <= 10'h3FF;
            s.tx_line <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign irq_out = s.irq;
    assign grant_dpu_out = s.grant_dpu;
    assign grant_rtu_out = s.grant_rtu;
    assign mem_addr_out = s.mem_addr;
    assign mem_data_out = s.mem_data;
    assign mem_we_out = s.mem_we;
    assign panel_sclk_out = s.pan_sclk;
    assign panel_sdo_out = s.pan_sh[7];
    assign panel_sample_out = s.pan_sample;
    assign panel_display_out = s.pan_disp;
    assign panel_indicator_out = s.pan_ind;
    assign dot_plucker_load_out = s.dp_load;
    assign fire_timer_load_out = s.ft_load;
    assign burst_req_out = s.burst_req;
    assign table_dma_req_out = s.tbl_busy;
    assign table_addr_out = s.tbl_addr;
    assign table_load_out = s.tbl_load;
    assign paper_data_out = s.paper_data;
    assign paper_stb_out = s.paper_stb;
    assign paper_now_out = s.paper_now;
    assign paper_trig_out = s.paper_trig;
    assign rsp_tx_out = s.tx_line;
    assign coil_sel_out = s.coil;
    assign fire_enable_out = s.fire_en;
    assign dpu_msg_out = s.msg;
    assign dpu_msg_valid_out = s.msg_valid;

    // Checks on the block's outputs and its status bits
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence

    property p_grant_excl;
        !(grant_dpu_out && grant_rtu_out);
    endproperty
    a_grant_excl: assert property (p_grant_excl) else $error("both bus owners granted");

    property p_dma_write;
        $rose(s.dma_pend) |-> ##[1:2] mem_we_out;
    endproperty
    a_dma_write: assert property (p_dma_write) else $error("input word not written");

    property p_addr_shift;
        dma_req_in && !s.dma_pend |=> mem_addr_out == {$past(dma_addr_in), 1'b0};
    endproperty
    a_addr_shift: assert property (p_addr_shift) else $error("address not doubled");

    property p_indicator;
        wr_ctrl && pwdata_in[pec_pkg::CT_INDIC] |=> s_pulse(panel_indicator_out);
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator strobe wrong");

    property p_table_dma;
        fire_timer_load_out |-> table_dma_req_out ##1 table_load_out;
    endproperty
    a_table_dma: assert property (p_table_dma) else $error("table transfer missing");

    property p_immediate;
        wr_paper |=> paper_stb_out && paper_now_out ##1 !paper_stb_out;
    endproperty
    a_immediate: assert property (p_immediate) else $error("paper command not immediate");

    property p_svc_hold;
        s.stat[pec_pkg::ST_SVC] && !tx_start && !clr[pec_pkg::ST_SVC]
            |=> s.stat[pec_pkg::ST_SVC];
    endproperty
    a_svc_hold: assert property (p_svc_hold) else $error("service request lost");

    property p_coil_wrap;
        stroke_rise && coil_sel_out == 6'h2F |=> coil_sel_out == 6'h00;
    endproperty
    a_coil_wrap: assert property (p_coil_wrap) else $error("coil scan wrap wrong");

    property p_halt;
        s.stat[pec_pkg::ST_SHORT] |-> !burst_req_out && !dot_plucker_load_out && !fire_enable_out;
    endproperty
    a_halt: assert property (p_halt) else $error("firing after coil short");

    property p_platen;
        $rose(s.s2[4]) |=> s.stat[pec_pkg::ST_PLATEN] ##1 dpu_msg_valid_out == 1'b0;
    endproperty
    a_platen: assert property (p_platen) else $error("platen fault not caught");

    property p_message;
        |(ev & pec_pkg::FAULT_BITS) |=> dpu_msg_valid_out && dpu_msg_out != 8'h00;
    endproperty
    a_message: assert property (p_message) else $error("fault message missing");
endmodule : pec_top

// ### tb/pec_far_model.sv
// Purpose: Far-side model of paper controller and ribbon processor
// Assumes: Same clock as the block, baud count shortened
// Notes: Status byte shows inverted data once released
`timescale 1ns/1ps
module pec_far_model #(
    parameter int BAUD_DIV = 8
) (
    input wire logic clk_in,
    output logic [7:0] paper_status_out,
    output logic paper_status_stb_out,
    output logic rsp_rx_out,
    output logic rsp_service_out
);
    // Idle levels at time zero
    initial begin
        paper_status_out = 8'h00;
        paper_status_stb_out = 1'b0;
        rsp_rx_out = 1'b1;
        rsp_service_out = 1'b0;
    end
    task automatic paper_report(input logic [7:0] st);
        paper_status_out <= st;
        repeat (4) @(posedge clk_in);
        paper_status_stb_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        paper_status_stb_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        paper_status_out <= ~st; // Released byte
    endtask : paper_report
    task automatic rsp_send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rsp_rx_out <= f[i];
            repeat (BAUD_DIV) @(posedge clk_in);
        end
    endtask : rsp_send
    task automatic need_service;
        rsp_service_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        rsp_service_out <= 1'b0;
    endtask : need_service
endmodule : pec_far_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the print engine coordinator
// Assumes: Shortened baud and stall counts
// Notes: Pulse counters feed the scenario checks
`timescale 1ns/1ps
module tb_top;
    localparam int BD = 8;
    logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic dpu_req_in = 1'b0, dma_req_in = 1'b0, sclk_q = 1'b0, er, pnow;
    logic [4:0] pin = 5'h00;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [15:0] dma_addr_in = 16'h0000, mem_data_out;
    logic [8:0] pdata_in = 9'h000;
    logic [7:0] table_addr_out, paper_data_out, paper_status_in, dpu_msg_out, msg, pd;
    logic [16:0] mem_addr_out;
    logic [5:0] coil_sel_out;
    logic pready_out, pslverr_out, irq_out, grant_dpu_out, grant_rtu_out, mem_we_out;
    logic panel_sclk_out, panel_sdo_out, panel_sample_out, panel_display_out;
    wire panel_sdi_in = panel_sdo_out; // Panel shift data looped back
    logic panel_indicator_out, dot_plucker_load_out, fire_timer_load_out, burst_req_out;
    logic table_dma_req_out, table_load_out, paper_stb_out, paper_now_out, paper_trig_out;
    logic paper_status_stb_in, rsp_tx_out, rsp_rx_in, rsp_service_in, fire_enable_out;
    logic dpu_msg_valid_out;
    int mismatches = 0, cmp_count = 0;
    int cnt [14] = '{default: 0};
    int s [14];
    pec_top #(.BAUD_DIV(BD), .STALL_CYC(50)) u_dut (.clk_in, .rst_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out,
        .dpu_req_in, .grant_dpu_out, .grant_rtu_out, .dma_req_in, .dma_addr_in, .pdata_in,
        .mem_addr_out, .mem_data_out, .mem_we_out, .panel_sclk_out, .panel_sdo_out,
        .panel_sdi_in, .panel_sample_out, .panel_display_out, .panel_indicator_out,
        .dot_plucker_load_out, .fire_timer_load_out, .stroke_in(pin[0]),
        .pickup_pulse_in(pin[1]), .burst_req_out, .table_dma_req_out, .table_addr_out,
        .table_load_out, .paper_data_out, .paper_stb_out, .paper_now_out, .paper_trig_out,
        .paper_status_in, .paper_status_stb_in, .rsp_tx_out, .rsp_rx_in, .rsp_service_in,
        .coil_sel_out, .coil_short_in(pin[2]), .hammer_fault_in(pin[3]),
        .platen_open_in(pin[4]), .fire_enable_out, .dpu_msg_out, .dpu_msg_valid_out);
    pec_far_model #(.BAUD_DIV(BD)) u_far (.clk_in, .paper_status_out(paper_status_in),
        .paper_status_stb_out(paper_status_stb_in), .rsp_rx_out(rsp_rx_in),
        .rsp_service_out(rsp_service_in));
    // Clock
    always #2 clk_in = ~clk_in;
    // Pulse counters and latched port values
    wire [13:0] ev = {panel_sclk_out & ~sclk_q, grant_dpu_out & grant_rtu_out, grant_dpu_out,
        dpu_msg_valid_out, burst_req_out, table_load_out, paper_trig_out, paper_stb_out,
        fire_timer_load_out, dot_plucker_load_out, panel_indicator_out, panel_display_out,
        panel_sample_out, mem_we_out};
    always @(posedge clk_in) begin
        sclk_q <= panel_sclk_out;
        for (int i = 0; i < 14; i++) if (ev[i] === 1'b1) cnt[i]++;
        if (paper_stb_out === 1'b1) {pnow, pd} <= {paper_now_out, paper_data_out};
        if (dpu_msg_valid_out === 1'b1) msg <= dpu_msg_out;
    end
    task automatic stop_test;
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    // Bus cycle, held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        cyc(1);
        penable_in <= 1'b1;
        do begin
            cyc(1);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        chk("pready", 1, pready_out);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        cyc(1);
    endtask : apb
    task automatic pulse(input int k);
        pin[k] <= 1'b1;
        cyc(5);
        pin[k] <= 1'b0;
        cyc(5);
    endtask : pulse
    // Reset levels and unmapped access
    task automatic t_regs;
        chk("tx_idle", 1, rsp_tx_out);
        chk("fire_en", 0, fire_enable_out);
        apb(0, pec_pkg::A_STAT, 0);
        chk("stat", 0, rd);
        apb(0, 8'h22, 0);
        chk("slverr", 1, er);
        chk("rd_bad", 0, rd);
    endtask : t_regs
    task automatic t_dma;
        s = cnt;
        dpu_req_in <= 1'b1;
        dma_addr_in <= 16'h8001;
        pdata_in <= 9'h1A5;
        cyc(4);
        dma_req_in <= 1'b1;
        cyc(1);
        dma_req_in <= 1'b0;
        cyc(8);
        dpu_req_in <= 1'b0;
        chk("we", 1, cnt[0] - s[0]);
        chk("addr", 17'h10002, mem_addr_out);
        chk("data", 16'h01A5, mem_data_out);
        chk("dpu_gnt", 1, cnt[11] > s[11]);
        chk("one_gnt", 0, cnt[12]);
    endtask : t_dma
    task automatic t_panel;
        s = cnt;
        apb(1, pec_pkg::A_CTRL, 32'h0E);
        cyc(3);
        chk("strobes", 3, cnt[3] - s[3] + cnt[2] - s[2] + cnt[1] - s[1]);
        apb(1, pec_pkg::A_PANEL, 32'hA5);
        cyc(80);
        apb(0, pec_pkg::A_PANEL, 0);
        chk("sclk", 8, cnt[13] - s[13]);
        chk("keys", 9'h0A5, rd[8:0]);
    endtask : t_panel
    task automatic t_row;
        apb(1, pec_pkg::A_CTRL, 1);
        s = cnt;
        apb(1, pec_pkg::A_ROW, 32'h032C);
        cyc(3);
        chk("row_mv", 9'h02C, {pnow, pd});
        chk("dpl", 1, cnt[4] - s[4]);
        apb(1, pec_pkg::A_PAPER, 32'h11);
        cyc(3);
        chk("now_mv", 9'h111, {pnow, pd});
        pulse(0);
        for (int i = 0; i < 3; i++) pulse(1);
        cyc(20);
        chk("ftl", 1, cnt[5] - s[5]);
        chk("trig", 1, cnt[7] - s[7]);
        chk("tload", pec_pkg::TABLE_WORDS, cnt[8] - s[8]);
        chk("taddr", pec_pkg::TABLE_WORDS, table_addr_out);
        chk("burst", 1, cnt[9] - s[9]);
        cyc(120);
        apb(0, pec_pkg::A_STAT, 0);
        chk("stall", 1, rd[pec_pkg::ST_STALL]);
    endtask : t_row
    task automatic t_short;
        apb(1, pec_pkg::A_STAT, 32'hFF);
        apb(1, pec_pkg::A_MASK, 32'h01);
        pulse(2);
        chk("irq", 1, irq_out);
        chk("fire_off", 0, fire_enable_out);
        s = cnt;
        apb(1, pec_pkg::A_ROW, 32'h0301);
        cyc(3);
        chk("no_row", 0, cnt[4] - s[4]);
        chk("held", 0, fire_enable_out);
        apb(1, pec_pkg::A_STAT, 32'h01);
        cyc(3);
        chk("fire_on", 1, fire_enable_out);
        chk("irq_clr", 0, irq_out);
        apb(1, pec_pkg::A_CTRL, 0);
        apb(1, pec_pkg::A_MASK, 0);
        pulse(3);
        chk("masked", 0, irq_out);
        chk("msg_ham", 8'h02, msg);
        pulse(4);
        apb(0, pec_pkg::A_STAT, 0);
        chk("platen", 1, rd[pec_pkg::ST_PLATEN]);
    endtask : t_short
    // coil scan wraps after full set
    task automatic t_coil;
        for (int i = 1; i < pec_pkg::COILS; i++) begin
            pulse(0);
            cyc(20);
        end
        chk("coil_wrap", 0, coil_sel_out);
    endtask : t_coil
    task automatic t_serial;
        logic [9:0] f;
        int n;
        u_far.need_service();
        cyc(20);
        apb(0, pec_pkg::A_STAT, 0);
        chk("svc_held", 1, rd[pec_pkg::ST_SVC]);
        chk("no_tx", 1, rsp_tx_out);
        apb(1, pec_pkg::A_SERIAL, 32'h5A);
        n = 0;
        while (rsp_tx_out !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        cyc(BD / 2);
        for (int i = 0; i < 10; i++) begin
            f[i] = rsp_tx_out;
            cyc(BD);
        end
        chk("frame", {1'b1, 8'h5A, 1'b0}, f);
        apb(0, pec_pkg::A_STAT, 0);
        chk("svc_clr", 0, rd[pec_pkg::ST_SVC]);
        u_far.rsp_send(8'h81);
        cyc(20);
        apb(0, pec_pkg::A_STAT, 0);
        chk("rx_flt", 2'b11, rd[7:6]);
        chk("msg_rsp", 8'h40, msg);
        u_far.paper_report(8'h01);
        apb(0, pec_pkg::A_PAPER, 0);
        chk("paper", 8'h01, rd[7:0]);
        chk("msg_pap", 8'h10, msg);
    endtask : t_serial
    // Watchdog
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    // Main sequence
    initial begin
        cyc(3);
        rst_in <= 1'b0;
        cyc(1);
        t_regs();
        t_dma();
        t_panel();
        t_row();
        t_short();
        t_coil();
        t_serial();
        stop_test();
    end
endmodule : tb_top
